// ==== inc/pot_pkg.sv ====
package pot_pkg;
  // timing
  localparam int CLK_HZ = 125_000_000;
  localparam int SCL_HZ = 400_000;
  localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam int NV_WRITE_CYCLE_TIME_US = 5000;
  localparam int NV_WC_CYC = NV_WRITE_CYCLE_TIME_US * (CLK_HZ / 1_000_000);

  // bus control byte; value of the fixed address bits is arbitrary
  localparam logic [5:0] DEV_ADDR_HI = 6'h2A;
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;

  // command byte layout: address, opcode, unused bit, data_msb_in_cmd
  localparam int CB_D8 = 0;
  localparam int CB_OP_LSB = 2;
  localparam int CB_ADDR_LSB = 4;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_INC = 2'h1;
  localparam logic [1:0] OP_DEC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;

  // memory map
  localparam logic [3:0] ADDR_WIPER0 = 4'h0;
  localparam logic [3:0] ADDR_WIPER1 = 4'h1;
  localparam logic [3:0] ADDR_NV_WIPER0 = 4'h2;
  localparam logic [3:0] ADDR_NV_WIPER1 = 4'h3;
  localparam logic [3:0] ADDR_TCON0 = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_WIPER2 = 4'h6;
  localparam logic [3:0] ADDR_WIPER3 = 4'h7;
  localparam logic [3:0] ADDR_NV_WIPER2 = 4'h8;
  localparam logic [3:0] ADDR_NV_WIPER3 = 4'h9;
  localparam logic [3:0] ADDR_TCON1 = 4'hA;
  localparam logic [3:0] ADDR_WP = 4'hF;
  localparam logic [8:0] WIPER_RESET = 9'h080;
  localparam logic [8:0] MEM_RESET = 9'h000;

  // status_flags fields
  localparam int ST_WP = 0;
  localparam int ST_LOCK_LSB = 1;
  localparam int ST_NV_BUSY = 5;

  // host register map (byte addresses) and fields
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_WDATA = 4'h4;
  localparam logic [3:0] HREG_RDATA = 4'h8;
  localparam logic [3:0] HREG_STATUS = 4'hC;
  localparam int HC_ADDR_LSB = 0;
  localparam int HC_OP_LSB = 4;
  localparam int HC_HV = 8;
  localparam int HC_A0 = 9;
  localparam int HS_BUSY = 0;
  localparam int HS_NACK = 1;

  function automatic logic is_volatile(input logic [3:0] a);
    return a == ADDR_WIPER0 || a == ADDR_WIPER1 || a == ADDR_TCON0 || a == ADDR_STATUS ||
           a == ADDR_WIPER2 || a == ADDR_WIPER3 || a == ADDR_TCON1;
  endfunction

  // {has lock, lock index} of the wiper that owns a location
  function automatic logic [2:0] lock_index(input logic [3:0] a);
    if (a == ADDR_WIPER0 || a == ADDR_NV_WIPER0) begin
      return 3'h4;
    end else if (a == ADDR_WIPER1 || a == ADDR_NV_WIPER1) begin
      return 3'h5;
    end else if (a == ADDR_WIPER2 || a == ADDR_NV_WIPER2) begin
      return 3'h6;
    end else if (a == ADDR_WIPER3 || a == ADDR_NV_WIPER3) begin
      return 3'h7;
    end
    return 3'h0;
  endfunction
endpackage

// ==== inc/pot_link_if.sv ====
`timescale 1ns/1ps
interface pot_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  logic high_voltage_cmd_pin;
  logic addr_bit_zero_pin;

  // open-drain wires with pull-ups
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport host(
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, high_voltage_cmd_pin, addr_bit_zero_pin,
    input scl, sda
  );
  modport device(
    output dev_sda_o, dev_sda_oe,
    input scl, sda, high_voltage_cmd_pin, addr_bit_zero_pin
  );
endinterface

// ==== src/pot_serial_command_rw.sv ====
`timescale 1ns/1ps
module pot_serial_command_rw #(
  parameter int unsigned NV_WC_CYC = pot_pkg::NV_WC_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  pot_link_if.device link,
  output logic [35:0] wiper_vol,
  output logic nv_write_active_flag
);
  localparam int WCW = $clog2(NV_WC_CYC + 1);
  localparam logic [WCW-1:0] WC_LAST = WCW'(NV_WC_CYC - 1);
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  typedef enum {IDLE, CTRL, CTRL_ACK, CMD, CMD_ACK, DATA, DATA_ACK, TX, TX_ACK, IGNORE} dev_state_t;
  logic [2:0] scl_s_q, sda_s_q, cb_li;
  logic [1:0] hv_s_q, a0_s_q, cmd_op_q, nv_op_q, cb_op;
  dev_state_t state_q;
  logic [3:0] cnt_q, cmd_addr_q, ptr_q, lock_q, nv_addr_q, cb_addr;
  logic [7:0] sh_q;
  logic sda_oe_q, hv_q, ack_ok_q, rw_q, cmd_d8_q, lo_next_q, mack_q, wp_q, busy_q, nv_pend_q;
  logic [8:0] mem_q [16];
  logic [8:0] nv_data_q, status_w, rd_word;
  logic [WCW-1:0] wc_cnt_q;
  logic scl_rise, scl_fall, start_det, stop_det, cb_nv, cb_locked, cmd_ok, ctrl_ok, vol_wr, nv_arm;

  // pins pass two flops; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      hv_s_q <= 2'h0;
      a0_s_q <= 2'h0;
    end else begin
      scl_s_q <= {scl_s_q[1:0], link.scl};
      sda_s_q <= {sda_s_q[1:0], link.sda};
      hv_s_q <= {hv_s_q[0], link.high_voltage_cmd_pin};
      a0_s_q <= {a0_s_q[0], link.addr_bit_zero_pin};
    end
  end

  assign scl_rise = scl_s_q[1] & ~scl_s_q[2];
  assign scl_fall = ~scl_s_q[1] & scl_s_q[2];
  assign start_det = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
  assign stop_det = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];

  always_comb begin
    status_w = '0;
    status_w[pot_pkg::ST_WP] = wp_q;
    status_w[pot_pkg::ST_LOCK_LSB +: 4] = lock_q;
    status_w[pot_pkg::ST_NV_BUSY] = busy_q;
  end
  assign rd_word = (ptr_q == pot_pkg::ADDR_STATUS) ? status_w : mem_q[ptr_q];

  // command byte qualification
  assign cb_addr = sh_q[pot_pkg::CB_ADDR_LSB +: 4];
  assign cb_op = sh_q[pot_pkg::CB_OP_LSB +: 2];
  assign cb_li = pot_pkg::lock_index(cb_addr);
  assign cb_nv = ~pot_pkg::is_volatile(cb_addr);
  assign cb_locked = cb_li[2] & lock_q[cb_li[1:0]] & ~hv_q;
  always_comb begin
    cmd_ok = 1'b0;
    case (cb_op)
      pot_pkg::OP_WRITE: begin
        cmd_ok = cb_addr != pot_pkg::ADDR_STATUS && !cb_locked && !(cb_nv && wp_q && !hv_q);
      end
      pot_pkg::OP_READ: begin
        cmd_ok = !cb_locked;
      end
      default: begin
        // high-voltage lock/protect change only
        cmd_ok = hv_q && cb_nv && (cb_li[2] || cb_addr == pot_pkg::ADDR_WP) && !busy_q;
      end
    endcase
    if ((cb_nv && busy_q) || nv_pend_q) begin
      cmd_ok = 1'b0;
    end
  end
  assign ctrl_ok = sh_q[7:1] == {pot_pkg::DEV_ADDR_HI, a0_s_q[1] | hv_s_q[1]} &&
                   !(sh_q[0] == pot_pkg::RW_READ && busy_q && !pot_pkg::is_volatile(ptr_q));

  assign vol_wr = state_q == DATA_ACK && scl_rise && pot_pkg::is_volatile(cmd_addr_q);
  assign nv_arm = scl_rise && ((state_q == DATA_ACK && !pot_pkg::is_volatile(cmd_addr_q)) ||
                  (state_q == CMD_ACK && ack_ok_q && (cmd_op_q == pot_pkg::OP_INC || cmd_op_q == pot_pkg::OP_DEC)));

  // serial protocol engine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      sda_oe_q <= 1'b0;
      hv_q <= 1'b0;
      ack_ok_q <= 1'b0;
      rw_q <= 1'b0;
      cmd_addr_q <= 4'h0;
      cmd_op_q <= 2'h0;
      cmd_d8_q <= 1'b0;
      ptr_q <= pot_pkg::ADDR_WIPER0;
      lo_next_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (start_det) begin
      state_q <= CTRL;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
      hv_q <= hv_s_q[1];
    end else if (stop_det) begin
      state_q <= IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        CTRL, CMD, DATA: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s_q[1]};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BYTE_BITS) begin
            cnt_q <= 4'h0;
            if (state_q == CTRL) begin
              state_q <= CTRL_ACK;
              ack_ok_q <= ctrl_ok;
              sda_oe_q <= ctrl_ok;
              rw_q <= sh_q[0];
            end else if (state_q == CMD) begin
              state_q <= CMD_ACK;
              ack_ok_q <= cmd_ok;
              sda_oe_q <= cmd_ok;
              cmd_addr_q <= cb_addr;
              cmd_op_q <= cb_op;
              cmd_d8_q <= sh_q[pot_pkg::CB_D8];
              if (cmd_ok) begin
                ptr_q <= cb_addr;
              end
            end else begin
              state_q <= DATA_ACK;
              ack_ok_q <= 1'b1;
              sda_oe_q <= 1'b1;
            end
          end
        end
        CTRL_ACK, CMD_ACK, DATA_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            if (!ack_ok_q) begin
              state_q <= IGNORE;
            end else if (state_q == CTRL_ACK && rw_q == pot_pkg::RW_READ) begin
              state_q <= TX;
              sh_q <= {7'h00, rd_word[8]};
              sda_oe_q <= 1'b1; // top bit of the high byte is always zero
              lo_next_q <= 1'b1;
            end else if (state_q == CMD_ACK && cmd_op_q == pot_pkg::OP_WRITE) begin
              state_q <= DATA;
            end else begin
              state_q <= CMD;
            end
          end
        end
        TX: begin
          if (scl_fall) begin
            if (cnt_q == LAST_TX_BIT) begin
              state_q <= TX_ACK;
              cnt_q <= 4'h0;
              sda_oe_q <= 1'b0;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_q <= ~sh_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        TX_ACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s_q[1];
          end else if (scl_fall) begin
            if (mack_q) begin
              state_q <= TX;
              sh_q <= lo_next_q ? rd_word[7:0] : {7'h00, rd_word[8]};
              sda_oe_q <= lo_next_q ? ~rd_word[7] : 1'b1;
              lo_next_q <= ~lo_next_q;
            end else begin
              state_q <= IGNORE;
            end
          end
        end
        default: begin
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // memory, lock state and nonvolatile programming cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= pot_pkg::MEM_RESET;
      end
      mem_q[pot_pkg::ADDR_WIPER0] <= pot_pkg::WIPER_RESET;
      mem_q[pot_pkg::ADDR_WIPER1] <= pot_pkg::WIPER_RESET;
      mem_q[pot_pkg::ADDR_WIPER2] <= pot_pkg::WIPER_RESET;
      mem_q[pot_pkg::ADDR_WIPER3] <= pot_pkg::WIPER_RESET;
      lock_q <= 4'h0;
      wp_q <= 1'b0;
      busy_q <= 1'b0;
      nv_pend_q <= 1'b0;
      nv_addr_q <= 4'h0;
      nv_data_q <= 9'h000;
      nv_op_q <= 2'h0;
      wc_cnt_q <= '0;
    end else begin
      if (vol_wr) begin
        mem_q[cmd_addr_q] <= {cmd_d8_q, sh_q};
      end
      if (nv_arm) begin
        nv_pend_q <= 1'b1;
        nv_addr_q <= cmd_addr_q;
        nv_data_q <= {cmd_d8_q, sh_q};
        nv_op_q <= cmd_op_q;
      end else if (stop_det && nv_pend_q) begin
        nv_pend_q <= 1'b0;
        busy_q <= 1'b1;
        wc_cnt_q <= '0;
      end else if (start_det || state_q == IGNORE) begin
        nv_pend_q <= 1'b0;
      end
      if (busy_q) begin
        wc_cnt_q <= wc_cnt_q + 1'b1;
        if (wc_cnt_q == WC_LAST) begin
          busy_q <= 1'b0;
          if (nv_op_q == pot_pkg::OP_WRITE) begin
            mem_q[nv_addr_q] <= nv_data_q;
          end else if (pot_pkg::lock_index(nv_addr_q) != 3'h0) begin
            lock_q[nv_addr_q == pot_pkg::ADDR_NV_WIPER0 ? 0 : nv_addr_q == pot_pkg::ADDR_NV_WIPER1 ? 1 :
                   nv_addr_q == pot_pkg::ADDR_NV_WIPER2 ? 2 : 3] <= nv_op_q == pot_pkg::OP_DEC;
          end else begin
            wp_q <= nv_op_q == pot_pkg::OP_DEC;
          end
        end
      end
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_oe_q;
  assign wiper_vol = {mem_q[pot_pkg::ADDR_WIPER3], mem_q[pot_pkg::ADDR_WIPER2],
                      mem_q[pot_pkg::ADDR_WIPER1], mem_q[pot_pkg::ADDR_WIPER0]};
  assign nv_write_active_flag = busy_q;
endmodule

// ==== src/pot_i2c_host.sv ====
`timescale 1ns/1ps
module pot_i2c_host (
  input wire logic clk,
  input wire logic resetn,
  pot_link_if.host link,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int QW = $clog2(pot_pkg::QTR_CYC);
  localparam logic [QW-1:0] Q_LAST = QW'(pot_pkg::QTR_CYC - 1);
  localparam logic [3:0] ACK_SLOT = 4'h8;

  typedef enum {K_START, K_WR, K_RD_ACK, K_RD_NACK, K_STOP} step_t;

  logic [1:0] sda_s_q;
  logic wait_q;
  logic [31:0] rdout_q;
  logic [9:0] cmd_q;
  logic [8:0] wdata_q;
  logic [8:0] rdata_q;
  logic busy_q;
  logic nack_q;
  logic [2:0] step_q;
  logic [1:0] ph_q;
  logic [QW-1:0] qcnt_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic take;
  logic start_cmd;
  logic [1:0] op;
  step_t kind;

  function automatic step_t step_of(input logic [1:0] o, input logic [2:0] i);
    if (i == 3'h0 || (o == pot_pkg::OP_READ && i == 3'h3)) begin
      return K_START;
    end else if (i == stop_idx(o)) begin
      return K_STOP;
    end else if (o == pot_pkg::OP_READ && i == 3'h5) begin
      return K_RD_ACK;
    end else if (o == pot_pkg::OP_READ && i == 3'h6) begin
      return K_RD_NACK;
    end
    return K_WR;
  endfunction

  function automatic logic [2:0] stop_idx(input logic [1:0] o);
    // a nonvolatile write always ends in stop
    return o == pot_pkg::OP_READ ? 3'h7 : o == pot_pkg::OP_WRITE ? 3'h4 : 3'h3;
  endfunction

  function automatic logic [7:0] byte_of(input logic [9:0] c, input logic [8:0] w, input logic [2:0] i);
    if (i == 3'h1) begin
      // the shared pin reads as a one while high voltage is applied
      return {pot_pkg::DEV_ADDR_HI, c[pot_pkg::HC_A0] | c[pot_pkg::HC_HV], pot_pkg::RW_WRITE};
    end else if (i == 3'h2) begin
      return {c[pot_pkg::HC_ADDR_LSB +: 4], c[pot_pkg::HC_OP_LSB +: 2], 1'b0, w[8]};
    end else if (i == 3'h4 && c[pot_pkg::HC_OP_LSB +: 2] == pot_pkg::OP_READ) begin
      return {pot_pkg::DEV_ADDR_HI, c[pot_pkg::HC_A0] | c[pot_pkg::HC_HV], pot_pkg::RW_READ};
    end
    return w[7:0];
  endfunction

  assign op = cmd_q[pot_pkg::HC_OP_LSB +: 2];
  assign kind = step_of(op, step_q);
  assign take = (avs_read | avs_write) & ~wait_q;
  assign start_cmd = take && avs_write && avs_address == pot_pkg::HREG_CMD && !busy_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_s_q <= 2'h3;
    end else begin
      sda_s_q <= {sda_s_q[0], link.sda};
    end
  end

  // slave handshake: one wait cycle, then answer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 1'b1;
      rdout_q <= 32'h0000_0000;
      wdata_q <= 9'h000;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
      if (avs_read && wait_q) begin
        if (avs_address == pot_pkg::HREG_CMD) begin
          rdout_q <= {22'h00_0000, cmd_q};
        end else if (avs_address == pot_pkg::HREG_WDATA) begin
          rdout_q <= {23'h00_0000, wdata_q};
        end else if (avs_address == pot_pkg::HREG_RDATA) begin
          rdout_q <= {23'h00_0000, rdata_q};
        end else if (avs_address == pot_pkg::HREG_STATUS) begin
          rdout_q <= {30'h0000_0000, nack_q, busy_q};
        end else begin
          rdout_q <= 32'h0000_0000;
        end
      end
      if (take && avs_write && avs_address == pot_pkg::HREG_WDATA) begin
        wdata_q <= avs_writedata[8:0];
      end
    end
  end

  // bit engine: quarter phases 0 scl low, 1 set sda, 2 scl high, 3 sample/start/stop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_q <= 10'h000;
      rdata_q <= 9'h000;
      busy_q <= 1'b0;
      nack_q <= 1'b0;
      step_q <= 3'h0;
      ph_q <= 2'h0;
      qcnt_q <= '0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_cmd) begin
      cmd_q <= avs_writedata[9:0];
      busy_q <= 1'b1;
      nack_q <= 1'b0;
      step_q <= 3'h0;
      ph_q <= 2'h0;
      qcnt_q <= '0;
      bit_q <= 4'h0;
    end else if (busy_q) begin
      qcnt_q <= (qcnt_q == Q_LAST) ? '0 : qcnt_q + 1'b1;
      if (qcnt_q == Q_LAST) begin
        ph_q <= ph_q + 2'h1;
        case (ph_q)
          2'h0: begin
            scl_oe_q <= 1'b1;
          end
          2'h1: begin
            case (kind)
              K_START: sda_oe_q <= 1'b0;
              K_STOP: sda_oe_q <= 1'b1;
              K_WR: sda_oe_q <= bit_q != ACK_SLOT && !sh_q[7];
              default: sda_oe_q <= bit_q == ACK_SLOT && kind == K_RD_ACK;
            endcase
          end
          2'h2: begin
            scl_oe_q <= 1'b0;
          end
          default: begin
            if (kind == K_STOP) begin
              sda_oe_q <= 1'b0;
              busy_q <= 1'b0;
            end else if (kind != K_START && bit_q != ACK_SLOT) begin
              sh_q <= {sh_q[6:0], sda_s_q[1]};
              bit_q <= bit_q + 4'h1;
            end else if (kind == K_WR && sda_s_q[1]) begin
              nack_q <= 1'b1;
              step_q <= stop_idx(op);
            end else begin
              if (kind == K_START) begin
                sda_oe_q <= 1'b1;
              end else if (kind == K_RD_ACK) begin
                rdata_q[8] <= sh_q[0];
              end else if (kind == K_RD_NACK) begin
                rdata_q[7:0] <= sh_q;
              end
              step_q <= step_q + 3'h1;
              bit_q <= 4'h0;
              sh_q <= byte_of(cmd_q, wdata_q, step_q + 3'h1);
            end
          end
        endcase
      end
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = scl_oe_q;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_oe_q;
  assign link.high_voltage_cmd_pin = busy_q & cmd_q[pot_pkg::HC_HV];
  assign link.addr_bit_zero_pin = cmd_q[pot_pkg::HC_A0];
  assign avs_readdata = rdout_q;
  assign avs_waitrequest = wait_q;
endmodule

// ==== test/pot_serial_command_rw_asserts.sv ====
`timescale 1ns/1ps
module pot_serial_command_rw_asserts #(
  parameter int unsigned NV_WC_CYC = pot_pkg::NV_WC_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic [35:0] wiper_vol,
  input wire logic nv_write_active_flag
);
  int unsigned busy_cnt_q;
  int unsigned drive_cnt_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= nv_write_active_flag ? busy_cnt_q + 1 : 0;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drive_cnt_q <= 0;
    end else begin
      drive_cnt_q <= dev_sda_oe ? drive_cnt_q + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ack_on_low; $rose(dev_sda_oe) |-> !scl; endproperty
  property p_hold_high; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
  property p_wiper_scl_high; $changed(wiper_vol) |-> scl; endproperty
  property p_wiper_in_ack; $changed(wiper_vol) |-> dev_sda_oe && $past(dev_sda_oe); endproperty
  property p_nv_after_stop; $rose(nv_write_active_flag) |-> scl && sda; endproperty
  property p_nv_len;
    $fell(nv_write_active_flag) |-> busy_cnt_q + 2 >= NV_WC_CYC && busy_cnt_q <= NV_WC_CYC + 2;
  endproperty
  property p_quiet_after_stop; scl && $past(scl) && $rose(sda) |=> !dev_sda_oe [*8]; endproperty
  property p_drive_bounded; drive_cnt_q <= 36 * pot_pkg::QTR_CYC; endproperty
  a_ack_on_low: assert property (p_ack_on_low) else $error("device drive began with clock high");
  a_hold_high: assert property (p_hold_high) else $error("device drive changed with clock high");
  a_wiper_scl_high: assert property (p_wiper_scl_high) else $error("wiper changed with clock low");
  a_wiper_in_ack: assert property (p_wiper_in_ack) else $error("wiper changed outside acknowledge");
  a_nv_after_stop: assert property (p_nv_after_stop) else $error("programming began on a busy bus");
  a_nv_len: assert property (p_nv_len) else $error("programming time wrong");
  a_quiet_after_stop: assert property (p_quiet_after_stop) else $error("device drove after stop");
  a_drive_bounded: assert property (p_drive_bounded) else $error("device held data line too long");
  c_nv_rise: cover property ($rose(nv_write_active_flag));
  c_nv_fall: cover property ($fell(nv_write_active_flag));
  c_wiper: cover property ($changed(wiper_vol));
endmodule

// ==== test/pot_serial_command_rw_tb.sv ====
`timescale 1ns/1ps
module pot_serial_command_rw_tb;
  localparam int NV_CYC = 22000;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [35:0] wiper_vol;
  logic nv_flag;
  logic [31:0] q;
  int err_count = 0;
  int check_count = 0;
  pot_link_if link ();
  pot_serial_command_rw #(.NV_WC_CYC(NV_CYC)) pot_serial_command_rw_i (.clk(clk), .resetn(resetn),
    .link(link.device), .wiper_vol(wiper_vol), .nv_write_active_flag(nv_flag));
  pot_i2c_host pot_i2c_host_i (.clk(clk), .resetn(resetn), .link(link.host), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  pot_serial_command_rw_asserts #(.NV_WC_CYC(NV_CYC)) pot_serial_command_rw_asserts_i (.clk(clk),
    .resetn(resetn), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda), .wiper_vol(wiper_vol),
    .nv_write_active_flag(nv_flag));
  always #4 clk = ~clk;
  task automatic stop_test();
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang();
    err_count++;
    $display("Error wait expected done seen timeout");
    stop_test();
  endtask
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus cycle; the edge after release is let pass before the next request
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
      if (n > 100) hang();
    end while (avs_waitrequest !== 1'h0);
    r = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask
  task automatic run(input logic [3:0] a, input logic [1:0] op, input logic hv, input logic [8:0] d,
    input logic nack);
    logic [31:0] st;
    int n;
    n = 0;
    av_xfer(1'h1, pot_pkg::HREG_WDATA, {23'h0, d}, st);
    av_xfer(1'h1, pot_pkg::HREG_CMD, {22'h0, 1'h0, hv, 2'h0, op, a}, st);
    do begin
      av_xfer(1'h0, pot_pkg::HREG_STATUS, 32'h0, st);
      n++;
      if (n > 20000) hang();
    end while (st[pot_pkg::HS_BUSY] !== 1'h0);
    check("nack", 36'(nack), 36'(st[pot_pkg::HS_NACK]));
    av_xfer(1'h0, pot_pkg::HREG_RDATA, 32'h0, q);
  endtask
  task automatic wait_nv(input logic v, input int lim);
    int n;
    n = 0;
    while (nv_flag !== v) begin
      @(posedge clk);
      n++;
      if (n > lim) hang();
    end
    check_count++;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    check("wiper_vol", {4{pot_pkg::WIPER_RESET}}, wiper_vol);
    check("nv_flag", 36'h0, 36'(nv_flag));
    av_xfer(1'h0, 4'h2, 32'h0, q);
    check("unmapped", 36'h0, 36'(q));
    run(pot_pkg::ADDR_WIPER0, pot_pkg::OP_WRITE, 1'h0, 9'h1A5, 1'h0);
    check("wiper0", 36'h1A5, 36'(wiper_vol[8:0]));
    run(pot_pkg::ADDR_NV_WIPER0, pot_pkg::OP_WRITE, 1'h0, 9'h055, 1'h0);
    wait_nv(1'h1, 200);
    run(pot_pkg::ADDR_STATUS, pot_pkg::OP_READ, 1'h0, 9'h000, 1'h0);
    check("status", 36'h020, 36'(q[8:0]));
    run(pot_pkg::ADDR_NV_WIPER1, pot_pkg::OP_WRITE, 1'h0, 9'h0AA, 1'h1);
    wait_nv(1'h0, 30000);
    run(pot_pkg::ADDR_NV_WIPER0, pot_pkg::OP_READ, 1'h0, 9'h000, 1'h0);
    check("nv_wiper0", 36'h055, 36'(q[8:0]));
    run(pot_pkg::ADDR_NV_WIPER0, pot_pkg::OP_DEC, 1'h1, 9'h000, 1'h0);
    wait_nv(1'h1, 200);
    // the next two commands run while the lock change is still programming
    run(pot_pkg::ADDR_WIPER3, pot_pkg::OP_WRITE, 1'h0, 9'h0F0, 1'h0);
    check("wiper3", 36'h0F0, 36'(wiper_vol[35:27]));
    run(pot_pkg::ADDR_STATUS, pot_pkg::OP_WRITE, 1'h0, 9'h000, 1'h1);
    wait_nv(1'h0, 30000);
    run(pot_pkg::ADDR_WIPER0, pot_pkg::OP_WRITE, 1'h0, 9'h033, 1'h1);
    check("wiper0", 36'h1A5, 36'(wiper_vol[8:0]));
    stop_test();
  end
endmodule
